// ==== shared/rflls_pkg.sv ====
// shared constants and types of the rf link layer sequencer
package rflls_pkg;
  // digital clock rate
  localparam int CLK_HZ = 10000000;
  // time base of the gap, active and extension periods
  localparam int STEP_US = 250;
  localparam int STEP_CYC = (STEP_US * (CLK_HZ / 1000000) > 0) ? STEP_US * (CLK_HZ / 1000000) : 1;
  // physical buffer depth in bytes
  localparam int BUF_DEPTH = 64;
  localparam logic [8:0] BUF_DEPTH_W = 9'h040;
  // low threshold levels for the 2-bit select field
  localparam logic [6:0] LT_LEVEL0 = 7'h04;
  localparam logic [6:0] LT_LEVEL1 = 7'h08;
  localparam logic [6:0] LT_LEVEL2 = 7'h10;
  localparam logic [6:0] LT_LEVEL3 = 7'h20;
  // wake modes
  localparam logic [1:0] MODE_WOT = 2'h0;
  localparam logic [1:0] MODE_WOR = 2'h1;
  // strobe commands
  typedef enum logic [2:0] {
    RFLLS_CMD_NONE,
    RFLLS_CMD_IDLE,
    RFLLS_CMD_SLEEP,
    RFLLS_CMD_TX,
    RFLLS_CMD_RX,
    RFLLS_CMD_BANK,
    RFLLS_CMD_OTHER
  } rflls_cmd_t;
  // sequencer states
  typedef enum logic [3:0] {
    RFLLS_SLEEP,
    RFLLS_IDLE,
    RFLLS_TX,
    RFLLS_RX,
    RFLLS_ACK_WAIT,
    RFLLS_ACK_TX,
    RFLLS_GAP,
    RFLLS_REARM,
    RFLLS_STREAM
  } rflls_state_t;
  // reset values
  localparam logic [3:0] RESEND_RST = 4'h0;
  localparam logic [31:0] TIMER_RST = 32'h0;
endpackage

// ==== rtl/rflls_period_timer.sv ====
// period counter with load, run and expiry pulse
`timescale 1ns/1ns
`default_nettype none
module rflls_period_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tick,
  input wire logic load,
  input wire logic run,
  input wire logic [WIDTH-1:0] value,
  output logic expired
);
  import rflls_pkg::*;
  logic [WIDTH-1:0] count_reg;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("rflls_period_timer width too small");
    end
  end

  // down counter, expiry pulses one cycle at zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= '0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      expired <= 1'b0;
      if (load)
      begin
        count_reg <= value;
      end
      else if (run && tick)
      begin
        if (count_reg == '0)
        begin
          expired <= 1'b1;
          count_reg <= value;
        end
        else
        begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/rflls_sequencer.sv ====
// link layer sequencer: streaming, continuous rx, resend/ack, wake modes
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - infinite mode lifts length limit; host refills buffer on each low threshold flag
// - ending infinite tx: clear mode, load remaining length, stop after all bytes; code counts the length latched at the tx strobe
// - infinite rx: host drains threshold bytes per flag; end likewise with rx length; code ignores infinite mode in rx, flag only in tx stream
// - continuous rx re-arms after delay, completion only for valid packets
// - packet before buffer read in continuous rx flags overflow and rx error
// - resend/ack enable: tx strobe starts resend, rx strobe starts ack
// - after sending, listen for ack for gap plus one times 250 us
// - valid ack gives tx completion and sleep; else resend while count below limit
// - ack side runs rx strobe to sleep, stores tag and crc of last packet
// - new good packet gives rx completion and ack; repeat gets ack only
// - bad crc or address: no interrupt, no ack, restart reception at once
// - after rx completion wait one gap before restarting reception
// - wake modes clocked from internal or external slow clock by select bit
// - timer single mode restarts on idle entry; continuous runs while enabled
// - in wake mode only idle, sleep and bank commands are accepted
// - wake on transmit: each period expiry sends buffer once then idles
// - with resend, wake transmit repeats to limit with one listen slot each
// - wake on receive: each expiry opens listen window of active plus one steps
// - preamble extends window by extension plus one steps; sync keeps receiving to packet end
// - good wake receive raises rx completion and stays in light sleep
// - wake receive with ack listens active plus extension, acks each good packet; code listens active plus one steps, extension only on preamble
// - low threshold select gives 4, 8, 16 or 32 bytes, flag below level
module rflls_sequencer #(
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire rflls_pkg::rflls_cmd_t strobe,
  input wire logic infinite_stream_enable,
  input wire logic low_threshold_enable,
  input wire logic [1:0] low_threshold_select,
  input wire logic low_threshold_clear,
  input wire logic [6:0] buffer_fill,
  input wire logic [LEN_W-1:0] transmit_length,
  input wire logic continuous_receive_enable,
  input wire logic [2:0] rearm_delay,
  input wire logic rx_buffer_read,
  input wire logic resend_ack_enable,
  input wire logic [3:0] resend_limit,
  input wire logic [7:0] receive_gap_period,
  input wire logic auto_wake_enable,
  input wire logic [1:0] auto_wake_mode,
  input wire logic wake_clock_select,
  input wire logic wake_timer_mode,
  input wire logic [15:0] wake_period,
  input wire logic [10:0] listen_active_period,
  input wire logic [15:0] listen_extend_period,
  input wire logic internal_slow_oscillator,
  input wire logic external_slow_clock_input,
  input wire logic radio_done,
  input wire logic pkt_valid,
  input wire logic pkt_crc_ok,
  input wire logic [1:0] packet_sequence_tag,
  input wire logic [15:0] pkt_crc,
  input wire logic preamble_seen,
  input wire logic sync_seen,
  output logic radio_tx,
  output logic radio_rx,
  output logic tx_complete,
  output logic rx_complete,
  output logic rx_error,
  output logic overflow,
  output logic low_threshold_flag,
  output logic [3:0] resend_count,
  output logic in_auto_wake
);
  import rflls_pkg::*;
  rflls_state_t state_reg;
  logic [3:0] resend_reg;
  logic [31:0] wait_reg;
  logic [1:0] tag_reg;
  logic [15:0] crc_reg;
  logic have_last_reg;
  logic unread_reg;
  logic ack_mode_reg;
  logic listening_reg;
  logic sync_reg;
  logic [LEN_W-1:0] left_reg;
  logic [2:0] int_sync;
  logic [2:0] ext_sync;
  logic slow_tick;
  logic wake_expired;
  logic timer_load;
  logic timer_run;
  logic [6:0] level;
  logic is_repeat;
  logic wake_on;
  logic [31:0] gap_cyc;
  logic [31:0] rearm_cyc;
  logic [31:0] active_cyc;
  logic [31:0] extend_cyc;

  initial
  begin
    if (LEN_W < 8)
    begin
      $error("rflls_sequencer length width too small");
    end
  end

  // slow clock select
  // two stage synchronisers, edge taken from stage two and three
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_sync <= 3'h0;
      ext_sync <= 3'h0;
    end
    else if (ce)
    begin
      int_sync <= {int_sync[1:0], internal_slow_oscillator};
      ext_sync <= {ext_sync[1:0], external_slow_clock_input};
    end
  end
  assign slow_tick = wake_clock_select ? (ext_sync[1] & ~ext_sync[2])
                                       : (int_sync[1] & ~int_sync[2]);

  // durations in system clock cycles
  assign gap_cyc = (32'(receive_gap_period) + 32'h1) * 32'(STEP_CYC);
  assign rearm_cyc = (32'(rearm_delay) + 32'h1) * 32'(STEP_CYC);
  assign active_cyc = (32'(listen_active_period) + 32'h1) * 32'(STEP_CYC);
  assign extend_cyc = (32'(listen_extend_period) + 32'h1) * 32'(STEP_CYC);
  assign wake_on = auto_wake_enable && (auto_wake_mode == MODE_WOT || auto_wake_mode == MODE_WOR);

  always_comb
  begin
    timer_load = 1'b0;
    timer_run = 1'b0;
    if (wake_on)
    begin
      if (wake_timer_mode)
      begin
        timer_run = in_auto_wake;
        timer_load = (strobe == RFLLS_CMD_IDLE);
      end
      else
      begin
        timer_run = (state_reg == RFLLS_IDLE) && in_auto_wake;
        timer_load = (state_reg != RFLLS_IDLE) || (strobe == RFLLS_CMD_IDLE);
      end
    end
  end

  rflls_period_timer #(
    .WIDTH(16)
  ) u_wake_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .tick(slow_tick),
    .load(timer_load),
    .run(timer_run),
    .value(wake_period),
    .expired(wake_expired)
  );

  always_comb
  begin
    case (low_threshold_select)
      2'h0: level = LT_LEVEL0;
      2'h1: level = LT_LEVEL1;
      2'h2: level = LT_LEVEL2;
      default: level = LT_LEVEL3;
    endcase
  end

  // low threshold flag, set wins over clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_threshold_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (low_threshold_enable && buffer_fill < level && state_reg == RFLLS_STREAM)
      begin
        low_threshold_flag <= 1'b1;
      end
      else if (low_threshold_clear)
      begin
        low_threshold_flag <= 1'b0;
      end
    end
  end

  // repeat detection on tag and crc
  assign is_repeat = have_last_reg && tag_reg == packet_sequence_tag && crc_reg == pkt_crc;

  // main sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= RFLLS_SLEEP;
      resend_reg <= RESEND_RST;
      wait_reg <= TIMER_RST;
      tag_reg <= 2'h0;
      crc_reg <= 16'h0;
      have_last_reg <= 1'b0;
      unread_reg <= 1'b0;
      ack_mode_reg <= 1'b0;
      listening_reg <= 1'b0;
      sync_reg <= 1'b0;
      left_reg <= '0;
      in_auto_wake <= 1'b0;
      radio_tx <= 1'b0;
      radio_rx <= 1'b0;
      tx_complete <= 1'b0;
      rx_complete <= 1'b0;
      rx_error <= 1'b0;
      overflow <= 1'b0;
      resend_count <= RESEND_RST;
    end
    else if (ce)
    begin
      tx_complete <= 1'b0;
      rx_complete <= 1'b0;
      rx_error <= 1'b0;
      resend_count <= resend_reg;
      if (rx_buffer_read)
      begin
        unread_reg <= 1'b0;
      end
      if (wait_reg != 32'h0)
      begin
        wait_reg <= wait_reg - 32'h1;
      end
      // wake mode ends in idle when enable clears or mode is neither MODE_WOT nor MODE_WOR
      if (!wake_on && in_auto_wake && state_reg == RFLLS_IDLE)
      begin
        in_auto_wake <= 1'b0;
        state_reg <= RFLLS_SLEEP;
      end
      if (strobe == RFLLS_CMD_SLEEP)
      begin
        state_reg <= RFLLS_SLEEP;
        in_auto_wake <= 1'b0;
        radio_tx <= 1'b0;
        radio_rx <= 1'b0;
        have_last_reg <= 1'b0;
      end
      else if (strobe == RFLLS_CMD_IDLE && wake_on)
      begin
        in_auto_wake <= 1'b1;
        state_reg <= RFLLS_IDLE;
        radio_tx <= 1'b0;
        radio_rx <= 1'b0;
      end
      else
      begin
        case (state_reg)
          RFLLS_SLEEP, RFLLS_IDLE:
          begin
            // other strobes ignored in wake mode
            if (!in_auto_wake && strobe == RFLLS_CMD_TX)
            begin
              resend_reg <= RESEND_RST;
              ack_mode_reg <= resend_ack_enable;
              left_reg <= transmit_length;
              radio_tx <= 1'b1;
              state_reg <= infinite_stream_enable ? RFLLS_STREAM : RFLLS_TX;
            end
            else if (!in_auto_wake && strobe == RFLLS_CMD_RX)
            begin
              ack_mode_reg <= resend_ack_enable;
              radio_rx <= 1'b1;
              state_reg <= RFLLS_RX;
            end
            else if (in_auto_wake && wake_expired)
            begin
              resend_reg <= RESEND_RST;
              ack_mode_reg <= resend_ack_enable;
              sync_reg <= 1'b0;
              if (auto_wake_mode == MODE_WOT)
              begin
                radio_tx <= 1'b1;
                state_reg <= RFLLS_TX;
              end
              else
              begin
                // listen window of active plus one steps
                radio_rx <= 1'b1;
                listening_reg <= 1'b0;
                wait_reg <= active_cyc;
                state_reg <= RFLLS_RX;
              end
            end
          end
          RFLLS_STREAM:
          begin
            // finish when the loaded length is sent
            if (!infinite_stream_enable && radio_done)
            begin
              if (left_reg <= LEN_W'(1))
              begin
                radio_tx <= 1'b0;
                tx_complete <= 1'b1;
                state_reg <= RFLLS_SLEEP;
              end
              left_reg <= left_reg - LEN_W'(1);
            end
          end
          RFLLS_TX:
          begin
            if (radio_done)
            begin
              radio_tx <= 1'b0;
              if (ack_mode_reg)
              begin
                // listen for ack during gap plus one steps
                radio_rx <= 1'b1;
                wait_reg <= gap_cyc;
                state_reg <= RFLLS_ACK_WAIT;
              end
              else
              begin
                tx_complete <= !in_auto_wake;
                state_reg <= in_auto_wake ? RFLLS_IDLE : RFLLS_SLEEP;
              end
            end
          end
          RFLLS_ACK_WAIT:
          begin
            if (radio_done && pkt_crc_ok)
            begin
              radio_rx <= 1'b0;
              tx_complete <= 1'b1;
              state_reg <= in_auto_wake ? RFLLS_IDLE : RFLLS_SLEEP;
            end
            else if (wait_reg == 32'h0)
            begin
              radio_rx <= 1'b0;
              if (resend_reg < resend_limit)
              begin
                resend_reg <= resend_reg + 4'h1;
                radio_tx <= 1'b1;
                state_reg <= RFLLS_TX;
              end
              else
              begin
                state_reg <= in_auto_wake ? RFLLS_IDLE : RFLLS_SLEEP;
              end
            end
          end
          RFLLS_RX:
          begin
            // preamble extends, sync holds to packet end
            if (in_auto_wake && preamble_seen && !listening_reg)
            begin
              listening_reg <= 1'b1;
              wait_reg <= wait_reg + extend_cyc;
            end
            if (sync_seen)
            begin
              sync_reg <= 1'b1;
            end
            if (radio_done)
            begin
              radio_rx <= 1'b0;
              sync_reg <= 1'b0;
              if (!(pkt_valid && pkt_crc_ok))
              begin
                // bad packet: restart reception at once
                radio_rx <= 1'b1;
              end
              else if (ack_mode_reg)
              begin
                // new packet completion, repeat ack only
                rx_complete <= !is_repeat;
                unread_reg <= unread_reg | !is_repeat;
                tag_reg <= packet_sequence_tag;
                crc_reg <= pkt_crc;
                have_last_reg <= 1'b1;
                radio_tx <= 1'b1;
                state_reg <= RFLLS_ACK_TX;
              end
              else if (continuous_receive_enable && !in_auto_wake)
              begin
                if (unread_reg)
                begin
                  overflow <= 1'b1;
                  rx_error <= 1'b1;
                end
                else
                begin
                  rx_complete <= 1'b1;
                  unread_reg <= 1'b1;
                end
                wait_reg <= rearm_cyc;
                state_reg <= RFLLS_REARM;
              end
              else
              begin
                // good wake receive parks in light sleep
                rx_complete <= 1'b1;
                unread_reg <= 1'b1;
                in_auto_wake <= 1'b0;
                state_reg <= RFLLS_SLEEP;
              end
            end
            else if (in_auto_wake && !sync_reg && !sync_seen && wait_reg == 32'h0)
            begin
              radio_rx <= 1'b0;
              state_reg <= RFLLS_IDLE;
            end
          end
          RFLLS_ACK_TX:
          begin
            if (radio_done)
            begin
              radio_tx <= 1'b0;
              if (in_auto_wake)
              begin
                // back to listening after the ack
                radio_rx <= 1'b1;
                state_reg <= RFLLS_RX;
              end
              else
              begin
                wait_reg <= gap_cyc;
                state_reg <= RFLLS_GAP;
              end
            end
          end
          RFLLS_GAP, RFLLS_REARM:
          begin
            if (wait_reg == 32'h0)
            begin
              radio_rx <= 1'b1;
              state_reg <= RFLLS_RX;
            end
          end
          default:
          begin
            state_reg <= RFLLS_SLEEP;
          end
        endcase
      end
      if (strobe == RFLLS_CMD_RX && !in_auto_wake)
      begin
        overflow <= 1'b0;
      end
    end
  end

  // checks
  // ack completion
  ack_done_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_ACK_WAIT && radio_done && pkt_crc_ok && strobe == RFLLS_CMD_NONE)
    |=> tx_complete) else $error("ack did not complete tx");
  bad_pkt_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_RX && radio_done && !pkt_crc_ok && strobe == RFLLS_CMD_NONE)
    |=> !rx_complete && radio_rx && !radio_tx) else $error("bad packet mishandled");
  limit_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_ACK_WAIT && wait_reg == 32'h0 && !radio_done
     && resend_reg >= resend_limit && strobe == RFLLS_CMD_NONE)
    |=> !tx_complete && !radio_tx) else $error("limit reached but not quiet");
  resend_step_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_ACK_WAIT && wait_reg == 32'h0 && !radio_done
     && resend_reg < resend_limit && strobe == RFLLS_CMD_NONE)
    |=> resend_reg == $past(resend_reg) + 4'h1) else $error("resend count stuck");
  repeat_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_RX && ack_mode_reg && radio_done && pkt_valid && pkt_crc_ok
     && is_repeat && strobe == RFLLS_CMD_NONE)
    |=> !rx_complete && radio_tx) else $error("repeat raised completion");
  overflow_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == RFLLS_RX && !ack_mode_reg && !in_auto_wake && continuous_receive_enable
     && radio_done && pkt_valid && pkt_crc_ok && unread_reg && strobe == RFLLS_CMD_NONE)
    |=> overflow && rx_error) else $error("overflow missed");
  // tx strobe ignored in wake mode
  wake_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && in_auto_wake && state_reg == RFLLS_IDLE && strobe == RFLLS_CMD_TX && !wake_expired)
    |=> !radio_tx) else $error("strobe accepted in wake mode");
  low_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && low_threshold_enable && state_reg == RFLLS_STREAM && buffer_fill < level)
    |=> low_threshold_flag) else $error("low threshold flag missed");
endmodule
`default_nettype wire

// ==== sim/rflls_host_model.sv ====
// host model that services threshold flags and reads the rx buffer
`timescale 1ns/1ns
`default_nettype none
module rflls_host_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic read_en,
  input wire logic low_threshold_flag,
  input wire logic rx_complete,
  output logic low_threshold_clear,
  output logic rx_buffer_read,
  output logic [7:0] services
);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_threshold_clear <= 1'b0;
      services <= 8'h00;
    end
    else
    begin
      low_threshold_clear <= low_threshold_flag & ~low_threshold_clear;
      if (low_threshold_flag & ~low_threshold_clear)
        services <= services + 8'h01;
    end
  end
  // read buffer within the gap, held off to provoke overflow
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rx_buffer_read <= 1'b0;
    else
      rx_buffer_read <= rx_complete & read_en;
  end
endmodule
`default_nettype wire

// ==== sim/rf_link_layer_sequencer_tb.sv ====
// testbench of the rf link layer sequencer
`timescale 1ns/1ns
`default_nettype none
module rf_link_layer_sequencer_tb;
  import rflls_pkg::*;
  logic clk = 1'b0;
  logic internal_slow_oscillator = 1'b0;
  logic external_slow_clock_input = 1'b0;
  logic nrst, ce, infinite_stream_enable, low_threshold_enable, low_threshold_clear;
  logic continuous_receive_enable, rx_buffer_read, resend_ack_enable, auto_wake_enable;
  logic wake_clock_select, wake_timer_mode, radio_done, pkt_valid, pkt_crc_ok;
  logic preamble_seen, sync_seen, read_en, radio_tx, radio_rx, tx_complete, rx_complete;
  logic rx_error, overflow, low_threshold_flag, in_auto_wake;
  rflls_cmd_t strobe;
  logic [1:0] low_threshold_select, auto_wake_mode, packet_sequence_tag;
  logic [6:0] buffer_fill;
  logic [7:0] transmit_length, receive_gap_period, services;
  logic [2:0] rearm_delay;
  logic [3:0] resend_limit, resend_count;
  logic [15:0] wake_period, listen_extend_period, pkt_crc;
  logic [10:0] listen_active_period;
  int errors, cmp_count, n_tx, n_rx, n_err;

  rflls_sequencer #(.LEN_W(8)) u_rflls_sequencer (.clk, .nrst, .ce, .strobe,
    .infinite_stream_enable, .low_threshold_enable, .low_threshold_select, .low_threshold_clear,
    .buffer_fill, .transmit_length, .continuous_receive_enable, .rearm_delay, .rx_buffer_read,
    .resend_ack_enable, .resend_limit, .receive_gap_period, .auto_wake_enable, .auto_wake_mode,
    .wake_clock_select, .wake_timer_mode, .wake_period, .listen_active_period,
    .listen_extend_period, .internal_slow_oscillator, .external_slow_clock_input, .radio_done,
    .pkt_valid, .pkt_crc_ok, .packet_sequence_tag, .pkt_crc, .preamble_seen, .sync_seen,
    .radio_tx, .radio_rx, .tx_complete, .rx_complete, .rx_error, .overflow,
    .low_threshold_flag, .resend_count, .in_auto_wake);
  rflls_host_model u_rflls_host_model (.clk, .nrst, .read_en, .low_threshold_flag,
    .rx_complete, .low_threshold_clear, .rx_buffer_read, .services);

  // system clock and two unrelated slow clocks
  always #50 clk = ~clk;
  always #1600 internal_slow_oscillator = ~internal_slow_oscillator;
  always #2300 external_slow_clock_input = ~external_slow_clock_input;

  // count completion and error pulses
  always @(posedge clk)
  begin
    if (tx_complete === 1'b1) n_tx <= n_tx + 1;
    if (rx_complete === 1'b1) n_rx <= n_rx + 1;
    if (rx_error === 1'b1) n_err <= n_err + 1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input rflls_cmd_t c);
    @(posedge clk);
    strobe <= c;
    @(posedge clk);
    strobe <= RFLLS_CMD_NONE;
  endtask

  task automatic done(input logic v, input logic [1:0] t, input logic [15:0] c);
    @(posedge clk);
    radio_done <= 1'b1;
    pkt_valid <= v;
    pkt_crc_ok <= v;
    packet_sequence_tag <= t;
    pkt_crc <= c;
    @(posedge clk);
    radio_done <= 1'b0;
  endtask

  // wait a bounded number of edges for one output to reach a level
  task automatic wait_on(input int sel, input int lim, input logic exp);
    logic s;
    s = ~exp;
    for (int i = 0; i < lim && s !== exp; i++)
    begin
      @(posedge clk);
      s = (sel == 0) ? radio_tx : (sel == 1) ? radio_rx :
          (sel == 2) ? low_threshold_flag : in_auto_wake;
    end
    chk(s, exp);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog against a hung sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end

  // main test sequence
  initial
  begin
    {nrst, infinite_stream_enable, low_threshold_enable, continuous_receive_enable} = 4'h0;
    {resend_ack_enable, auto_wake_enable, wake_clock_select, wake_timer_mode} = 4'h0;
    {radio_done, pkt_valid, pkt_crc_ok, preamble_seen, sync_seen} = 5'h00;
    {ce, read_en} = 2'h3;
    strobe = RFLLS_CMD_NONE;
    {low_threshold_select, auto_wake_mode, packet_sequence_tag} = 6'h00;
    buffer_fill = 7'h40;
    {transmit_length, receive_gap_period} = 16'h0000;
    rearm_delay = 3'h0;
    resend_limit = 4'h2;
    {wake_period, listen_extend_period, pkt_crc} = 48'h0;
    listen_active_period = 11'h000;
    {errors, cmp_count, n_tx, n_rx, n_err} = 160'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({radio_tx, radio_rx, overflow, low_threshold_flag, in_auto_wake}, 16'h0000);
    $display("reset test done");
    resend_ack_enable <= 1'b1;
    cmd(RFLLS_CMD_TX);
    wait_on(0, 4, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    wait_on(1, 4, 1'b1);
    done(1'b1, 2'h0, 16'h0000);
    repeat (3) @(posedge clk);
    chk(16'(n_tx), 16'h0001);
    chk(radio_rx, 1'b0);
    resend_limit <= 4'h1;
    cmd(RFLLS_CMD_TX);
    wait_on(0, 4, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    wait_on(1, 4, 1'b1);
    repeat (2400) @(posedge clk);
    chk(radio_tx, 1'b0);
    wait_on(0, 300, 1'b1);
    @(posedge clk);
    chk(resend_count, 4'h1);
    done(1'b0, 2'h0, 16'h0000);
    repeat (2700) @(posedge clk);
    chk({radio_tx, radio_rx}, 2'h0);
    chk(16'(n_tx), 16'h0001);
    $display("resend test done");
    cmd(RFLLS_CMD_RX);
    wait_on(1, 4, 1'b1);
    done(1'b1, 2'h1, 16'h1234);
    repeat (3) @(posedge clk);
    chk(16'(n_rx), 16'h0001);
    wait_on(0, 4, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    repeat (2300) @(posedge clk);
    chk(radio_rx, 1'b0);
    wait_on(1, 400, 1'b1);
    done(1'b1, 2'h1, 16'h1234);
    wait_on(0, 4, 1'b1);
    chk(16'(n_rx), 16'h0001);
    done(1'b0, 2'h0, 16'h0000);
    wait_on(1, 2700, 1'b1);
    done(1'b0, 2'h2, 16'h5555);
    wait_on(1, 4, 1'b1);
    chk({radio_tx, 15'(n_rx)}, 16'h0001);
    cmd(RFLLS_CMD_SLEEP);
    wait_on(1, 4, 1'b0);
    resend_ack_enable <= 1'b0;
    $display("ack test done");
    {continuous_receive_enable, read_en} <= 2'h2;
    cmd(RFLLS_CMD_RX);
    wait_on(1, 4, 1'b1);
    done(1'b1, 2'h0, 16'h0001);
    repeat (3) @(posedge clk);
    chk(16'(n_rx), 16'h0002);
    wait_on(1, 2800, 1'b1);
    done(1'b0, 2'h0, 16'h0002);
    repeat (3) @(posedge clk);
    chk(16'(n_rx), 16'h0002);
    wait_on(1, 2800, 1'b1);
    done(1'b1, 2'h1, 16'h0003);
    repeat (3) @(posedge clk);
    chk({overflow, 15'(n_err)}, 16'h8001);
    cmd(RFLLS_CMD_SLEEP);
    {continuous_receive_enable, read_en} <= 2'h1;
    $display("continuous test done");
    {low_threshold_enable, infinite_stream_enable} <= 2'h3;
    transmit_length <= 8'h10;
    cmd(RFLLS_CMD_TX);
    for (int i = 0; i < 4; i++)
    begin
      low_threshold_select <= 2'(i);
      buffer_fill <= 7'h04 << i;
      repeat (4) @(posedge clk);
      chk(low_threshold_flag, 1'b0);
      buffer_fill <= (7'h04 << i) - 7'h01;
      wait_on(2, 4, 1'b1);
      buffer_fill <= 7'h40;
      repeat (6) @(posedge clk);
      chk(low_threshold_flag, 1'b0);
    end
    chk(services, 8'h04);
    infinite_stream_enable <= 1'b0;
    repeat (15) done(1'b0, 2'h0, 16'h0000);
    chk(radio_tx, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    repeat (2) @(posedge clk);
    chk({radio_tx, 15'(n_tx)}, 16'h0002);
    $display("threshold test done");
    {auto_wake_enable, wake_timer_mode} <= 2'h3;
    auto_wake_mode <= MODE_WOT;
    wake_period <= 16'h0003;
    cmd(RFLLS_CMD_IDLE);
    wait_on(3, 4, 1'b1);
    cmd(RFLLS_CMD_TX);
    repeat (2) @(posedge clk);
    chk(radio_tx, 1'b0);
    wait_on(0, 400, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    wait_on(0, 4, 1'b0);
    wake_clock_select <= 1'b1;
    wait_on(0, 600, 1'b1);
    done(1'b0, 2'h0, 16'h0000);
    cmd(RFLLS_CMD_SLEEP);
    wait_on(3, 4, 1'b0);
    wake_timer_mode <= 1'b0;
    auto_wake_mode <= MODE_WOR;
    cmd(RFLLS_CMD_IDLE);
    wait_on(1, 600, 1'b1);
    preamble_seen <= 1'b1;
    @(posedge clk);
    preamble_seen <= 1'b0;
    repeat (4000) @(posedge clk);
    chk(radio_rx, 1'b1);
    wait_on(1, 1200, 1'b0);
    wait_on(1, 600, 1'b1);
    done(1'b1, 2'h3, 16'h00aa);
    repeat (3) @(posedge clk);
    chk({in_auto_wake, 15'(n_rx)}, 16'h0003);
    $display("wake test done");
    summarize();
  end
endmodule
`default_nettype wire
